// ==== hw/remote_map_pkg.sv ====
// Constants and types shared by the remote status bit mapper
package remote_map_pkg;

  // AHB-Lite register offsets (byte addresses)
  localparam logic [7:0] OFF_SEL_A = 8'h00;
  localparam logic [7:0] OFF_SEL_B = 8'h04;
  localparam logic [7:0] OFF_SEL_C = 8'h08;
  localparam logic [7:0] OFF_GEN_0 = 8'h0C;
  localparam logic [7:0] OFF_GEN_1 = 8'h10;
  localparam logic [7:0] OFF_GEN_2 = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_REPLY = 8'h1C;

  // Function codes
  localparam logic [15:0] FC_RUN = 16'h0000;
  localparam logic [15:0] FC_AT_SPEED = 16'h0001;
  localparam logic [15:0] FC_OVERLOAD = 16'h0003;
  localparam logic [15:0] FC_FREQ_DETECT = 16'h0004;
  localparam logic [15:0] FC_REGEN_PRE = 16'h0007;
  localparam logic [15:0] FC_THERMAL_PRE = 16'h0008;
  localparam logic [15:0] FC_OP_READY = 16'h000B;
  localparam logic [15:0] FC_CURRENT_DET = 16'h000C;
  localparam logic [15:0] FC_ZERO_CURRENT = 16'h000D;
  localparam logic [15:0] FC_POWEROFF_FAULT = 16'h005B;
  localparam logic [15:0] FC_WARNING = 16'h0062;
  localparam logic [15:0] FC_FAULT = 16'h0063;
  localparam logic [15:0] FC_INVERT_OFFSET = 16'h0064;
  localparam logic [15:0] FC_INVERT_LIMIT = 16'h00C8;
  localparam logic [15:0] FC_NONE = 16'h270F;

  // Reset values of the selectors
  localparam logic [15:0] RST_SEL_A = FC_RUN;
  localparam logic [15:0] RST_SEL_B = FC_FREQ_DETECT;
  localparam logic [15:0] RST_SEL_C = FC_FAULT;
  localparam logic [15:0] RST_GEN = FC_NONE;

  // Reply code values
  localparam logic [15:0] REPLY_OK = 16'h0000;
  localparam logic [15:0] REPLY_FAIL = 16'h0001;

  // Bus constants and command channel count
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ = 2'b11;
  localparam int NUM_CMD = 4;

  // Command channel index
  localparam int CH_MON = 0;
  localparam int CH_VOL = 1;
  localparam int CH_PERS = 2;
  localparam int CH_INSTR = 3;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_BUSY = 2'b01,
    HS_DONE = 2'b10
  } handshake_t;

  // Drive state seen by the mapper
  typedef struct packed {
    logic fwdRun;
    logic revRun;
    logic running;
    logic atSpeed;
    logic overload;
    logic freqDetect;
    logic regenPre;
    logic thermalPre;
    logic opReady;
    logic currentDetect;
    logic zeroCurrent;
    logic warning;
    logic fault;
    logic powerOffFault;
    logic tripped;
    logic optionError;
    logic initDone;
  } driveState_t;

  // Remote input bits sent to the master station
  typedef struct packed {
    logic stationReady;
    logic errorFlag;
    logic instructionDone;
    logic persistentWriteDone;
    logic volatileWriteDone;
    logic monitorAck;
    logic generalOut2;
    logic generalOut1;
    logic generalOut0;
    logic assignableBitC;
    logic assignableBitB;
    logic overloadFlag;
    logic atSpeedFlag;
    logic assignableBitA;
    logic revRunningFlag;
    logic fwdRunningFlag;
  } remoteBits_t;

endpackage : remote_map_pkg

// ==== hw/remote_status_bit_mapper.sv ====
// Remote status bit mapper with AHB-Lite selector registers
`timescale 1ns/1ps
module remote_status_bit_mapper
  import remote_map_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire driveState_t driveState,
  input wire logic monitorRequest,
  input wire logic volatileWriteRequest,
  input wire logic persistentWriteRequest,
  input wire logic instructionRequest,
  input wire logic [NUM_CMD-1:0] cmdDone,
  input wire logic instrFail,
  output logic [NUM_CMD-1:0] cmdStart,
  output logic [15:0] replyCode,
  output remoteBits_t remoteBits
);

  ////////////////////////////////////////////////////////////////////////
  // Function code decoder

  function automatic logic decodeCode(input logic [15:0] code,
                                      input driveState_t s);
    logic inv;
    logic [15:0] base;
    logic hit;
    logic valid;
    inv = (code >= FC_INVERT_OFFSET) && (code < FC_INVERT_LIMIT);
    base = inv ? code - FC_INVERT_OFFSET : code;
    valid = 1'b1;
    hit = 1'b0;
    unique case (base)
      FC_RUN: hit = s.running;
      FC_AT_SPEED: hit = s.atSpeed;
      FC_OVERLOAD: hit = s.overload;
      FC_FREQ_DETECT: hit = s.freqDetect;
      FC_REGEN_PRE: hit = s.regenPre;
      FC_THERMAL_PRE: hit = s.thermalPre;
      FC_OP_READY: hit = s.opReady;
      FC_CURRENT_DET: hit = s.currentDetect;
      FC_ZERO_CURRENT: hit = s.zeroCurrent;
      FC_POWEROFF_FAULT: hit = s.powerOffFault;
      FC_WARNING: hit = s.warning;
      FC_FAULT: hit = s.fault;
      default: valid = 1'b0; // 9999 and unknown codes
    endcase
    return valid & (hit ^ inv);
  endfunction : decodeCode

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states

  logic [15:0] selA_q;
  logic [15:0] selB_q;
  logic [15:0] selC_q;
  logic [15:0] gen0_q;
  logic [15:0] gen1_q;
  logic [15:0] gen2_q;
  logic [15:0] reply_q;
  logic wrPend_q;
  logic [7:0] wrAddr_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  remoteBits_t bits_q;
  remoteBits_t bits_d;

  wire logic addrPhase;
  wire logic rdReq;
  wire logic wrReq;
  wire logic [7:0] offset;
  wire logic [15:0] wrVal;
  wire logic [31:0] rdVal;

  assign addrPhase = hsel && hready &&
                     (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign rdReq = addrPhase && !hwrite;
  assign wrReq = addrPhase && hwrite;
  assign offset = haddr[7:0];
  assign wrVal = hwdata[15:0];

  // Unmapped offsets read as zero; writes there are dropped
  assign rdVal =
    (haddr[31:8] != 24'h000000) ? 32'h00000000 :
    (offset == OFF_SEL_A) ? {16'h0000, selA_q} :
    (offset == OFF_SEL_B) ? {16'h0000, selB_q} :
    (offset == OFF_SEL_C) ? {16'h0000, selC_q} :
    (offset == OFF_GEN_0) ? {16'h0000, gen0_q} :
    (offset == OFF_GEN_1) ? {16'h0000, gen1_q} :
    (offset == OFF_GEN_2) ? {16'h0000, gen2_q} :
    (offset == OFF_STATUS) ? {16'h0000, bits_q} :
    (offset == OFF_REPLY) ? {16'h0000, reply_q} :
    32'h00000000;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      hrdata_q <= 32'h00000000;
      hreadyout_q <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      wrPend_q <= wrReq && (haddr[31:8] == 24'h000000);
      wrAddr_q <= offset;
      if (rdReq) begin
        hrdata_q <= rdVal;
      end
    end
  end

  // Selectors: reset values give the documented defaults
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      selA_q <= RST_SEL_A;
      selB_q <= RST_SEL_B;
      selC_q <= RST_SEL_C;
      gen0_q <= RST_GEN;
      gen1_q <= RST_GEN;
      gen2_q <= RST_GEN;
    end else if (wrPend_q) begin
      unique case (wrAddr_q)
        OFF_SEL_A: selA_q <= wrVal;
        OFF_SEL_B: selB_q <= wrVal;
        OFF_SEL_C: selC_q <= wrVal;
        OFF_GEN_0: gen0_q <= wrVal;
        OFF_GEN_1: gen1_q <= wrVal;
        OFF_GEN_2: gen2_q <= wrVal;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command handshakes

  handshake_t hs_q [NUM_CMD];
  logic [NUM_CMD-1:0] reqPrev_q;
  logic [NUM_CMD-1:0] start_q;

  wire logic [NUM_CMD-1:0] req;
  wire logic [NUM_CMD-1:0] reqRise;
  wire logic [NUM_CMD-1:0] ackBit;

  assign req = {instructionRequest, persistentWriteRequest,
                volatileWriteRequest, monitorRequest};
  assign reqRise = req & ~reqPrev_q;

  for (genvar i = 0; i < NUM_CMD; i++) begin : gAck
    assign ackBit[i] = (hs_q[i] == HS_DONE);
  end

  // Each channel: rise starts work, done raises ack, fall clears it
  // One process for all channels keeps a single driver per variable
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_CMD; i++) begin
        hs_q[i] <= HS_IDLE;
      end
      start_q <= '0;
    end else begin
      start_q <= '0;
      for (int i = 0; i < NUM_CMD; i++) begin
        unique case (hs_q[i])
          HS_IDLE: begin
            if (reqRise[i]) begin
              hs_q[i] <= HS_BUSY;
              start_q[i] <= 1'b1;
            end
          end
          HS_BUSY: begin
            // Withdrawn request abandons the ack, not the work
            if (!req[i]) begin
              hs_q[i] <= HS_IDLE;
            end else if (cmdDone[i]) begin
              hs_q[i] <= HS_DONE;
            end
          end
          HS_DONE: begin
            if (!req[i]) begin
              hs_q[i] <= HS_IDLE;
            end
          end
          default: hs_q[i] <= HS_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reqPrev_q <= '0;
    end else begin
      reqPrev_q <= req;
    end
  end

  // Reply code follows the outcome of each instruction run whose request is not withdrawn before done
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reply_q <= REPLY_OK;
    end else if (hs_q[CH_INSTR] == HS_BUSY && cmdDone[CH_INSTR]) begin
      reply_q <= instrFail ? REPLY_FAIL : REPLY_OK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Remote bit mapping

  always_comb begin
    bits_d.fwdRunningFlag = driveState.fwdRun;
    bits_d.revRunningFlag = driveState.revRun;
    bits_d.assignableBitA = decodeCode(selA_q, driveState);
    // Fixed wiring; no selector reaches these two
    bits_d.atSpeedFlag = driveState.atSpeed;
    bits_d.overloadFlag = driveState.overload;
    bits_d.assignableBitB = decodeCode(selB_q, driveState);
    bits_d.assignableBitC = decodeCode(selC_q, driveState);
    bits_d.generalOut0 = decodeCode(gen0_q, driveState);
    bits_d.generalOut1 = decodeCode(gen1_q, driveState);
    bits_d.generalOut2 = decodeCode(gen2_q, driveState);
    bits_d.monitorAck = ackBit[CH_MON];
    bits_d.volatileWriteDone = ackBit[CH_VOL];
    bits_d.persistentWriteDone = ackBit[CH_PERS];
    bits_d.instructionDone = ackBit[CH_INSTR];
    bits_d.errorFlag = driveState.tripped;
    // Master gates its link traffic on this bit
    bits_d.stationReady = driveState.initDone &&
                          !driveState.tripped;
    if (driveState.optionError) begin
      bits_d = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bits_q <= '0;
    end else begin
      bits_q <= bits_d;
    end
  end

  assign remoteBits = bits_q;
  assign cmdStart = start_q;
  assign replyCode = reply_q;
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;

endmodule : remote_status_bit_mapper

// ==== verification/remote_map_asserts.sv ====
// Port-level assertions for the remote status bit mapper
`timescale 1ns/1ps
module remote_map_asserts
  import remote_map_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire driveState_t driveState,
  input wire logic instructionRequest,
  input wire logic [NUM_CMD-1:0] cmdDone,
  input wire remoteBits_t remoteBits
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  fwd_run_a: assert property (!driveState.optionError |=>
    remoteBits.fwdRunningFlag == $past(driveState.fwdRun))
    else $error("forward bit wrong");
  rev_run_a: assert property (!driveState.optionError |=>
    remoteBits.revRunningFlag == $past(driveState.revRun))
    else $error("reverse bit wrong");
  speed_flag_a: assert property (!driveState.optionError |=>
    remoteBits.atSpeedFlag == $past(driveState.atSpeed))
    else $error("at-speed bit wrong");
  load_flag_a: assert property (!driveState.optionError |=>
    remoteBits.overloadFlag == $past(driveState.overload))
    else $error("overload bit wrong");
  opt_err_a: assert property (driveState.optionError |=>
    remoteBits == '0)
    else $error("bits not forced off");
  err_flag_a: assert property (!driveState.optionError |=>
    remoteBits.errorFlag == $past(driveState.tripped))
    else $error("error flag wrong");
  ready_bit_a: assert property (!driveState.optionError |=>
    remoteBits.stationReady ==
    $past(driveState.initDone && !driveState.tripped))
    else $error("station ready wrong");
  mon_ack_a: assert property ($rose(remoteBits.monitorAck) |->
    $past(cmdDone[CH_MON], 2))
    else $error("monitor ack without load");
  instr_done_a: assert property ($rose(remoteBits.instructionDone) |->
    $past(cmdDone[CH_INSTR], 2))
    else $error("instruction done early");
  instr_clear_a: assert property ($fell(instructionRequest) |->
    ##2 !remoteBits.instructionDone)
    else $error("instruction done stuck");
  cover property ($rose(remoteBits.monitorAck));
  cover property ($rose(remoteBits.instructionDone));
  cover property (driveState.optionError);
endmodule : remote_map_asserts

// ==== verification/master_station_model.sv ====
// Behavioural master station raising the command bits
`timescale 1ns/1ps
module master_station_model
  import remote_map_pkg::*;
(
  input wire logic clk,
  input wire remoteBits_t remoteBits,
  output logic [NUM_CMD-1:0] req
);
  logic [NUM_CMD-1:0] ack;
  assign ack = {remoteBits.instructionDone, remoteBits.persistentWriteDone,
    remoteBits.volatileWriteDone, remoteBits.monitorAck};
  initial req = '0;
  // Bounded waits, so a dead slave shows as a failed handshake
  task automatic handshake(input int ch, output logic ok);
    int n;
    ok = 1'b0;
    n = 0;
    while (remoteBits.stationReady !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) return;
    @(posedge clk) req[ch] <= 1'b1;
    n = 0;
    while (ack[ch] !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    req[ch] <= 1'b0;
    if (n == 20) return;
    repeat (3) @(posedge clk);
    ok = (ack[ch] === 1'b0);
  endtask : handshake
endmodule : master_station_model

// ==== verification/test_remote_status_bit_mapper.sv ====
// Self-checking bench for the remote status bit mapper
`timescale 1ns/1ps
module test_remote_status_bit_mapper;
  import remote_map_pkg::*;
  logic clk, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, instrFail = 1'b0;
  logic hreadyout, hresp, ok;
  wire logic hready;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [NUM_CMD-1:0] cmdDone = '0, doneDly = '0, cmdStart, req;
  logic [15:0] replyCode;
  driveState_t driveState = '0;
  remoteBits_t remoteBits;
  int failCount = 0, totalChecks = 0;
  logic [15:0] codes[12] = '{FC_RUN, FC_AT_SPEED, FC_OVERLOAD,
    FC_FREQ_DETECT, FC_REGEN_PRE, FC_THERMAL_PRE, FC_OP_READY,
    FC_CURRENT_DET, FC_ZERO_CURRENT, FC_WARNING, FC_FAULT, FC_POWEROFF_FAULT};
  assign hready = hreadyout;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  remote_status_bit_mapper dut_u (.clk(clk), .rst_b(rst_b), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .driveState(driveState),
    .monitorRequest(req[0]), .volatileWriteRequest(req[1]),
    .persistentWriteRequest(req[2]), .instructionRequest(req[3]),
    .cmdDone(cmdDone), .instrFail(instrFail), .cmdStart(cmdStart),
    .replyCode(replyCode), .remoteBits(remoteBits));
  master_station_model mstU (.clk(clk), .remoteBits(remoteBits), .req(req));
  // Drive side answers each start two cycles later
  always @(posedge clk) begin
    doneDly <= cmdStart;
    cmdDone <= doneDly;
  end
  ////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("mismatch at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask : check
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdata = hrdata;
  endtask : bus
  task setDs(input driveState_t v);
    @(posedge clk) driveState <= v;
    repeat (2) @(posedge clk);
  endtask : setDs
  task endSim;
    if (failCount == 0 && totalChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : endSim
  ////////////////////////////////////////
  task regsTest;
    logic [15:0] rv[6] = '{FC_RUN, FC_FREQ_DETECT, FC_FAULT, FC_NONE,
      FC_NONE, FC_NONE};
    bus(1'b1, 8'h20, 32'h0000FFFF);
    check(hresp, 1'b0);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0);
      check(rdata, {16'h0000, rv[i]});
    end
    bus(1'b0, 8'h20, 32'h0);
    check(rdata, 32'h0);
  endtask : regsTest
  task codeTest;
    for (int i = 0; i < 12; i++) begin
      bus(1'b1, OFF_SEL_A, {16'h0000, codes[i]});
      bus(1'b1, OFF_GEN_1, {16'h0000, codes[i] + FC_INVERT_OFFSET});
      setDs(17'h1 << (14 - i));
      check(remoteBits.assignableBitA, 1'b1);
      check(remoteBits.generalOut1, 1'b0);
      setDs('0);
      check(remoteBits.generalOut1, 1'b1);
    end
    setDs(17'h1FFFD);
    check(remoteBits.generalOut2, 1'b0);
    check(remoteBits.assignableBitB, 1'b1);
  endtask : codeTest
  task dirTest;
    setDs(17'h10001);
    check(remoteBits.fwdRunningFlag, 1'b1);
    check(remoteBits.revRunningFlag, 1'b0);
    setDs(17'h08001);
    check(remoteBits.fwdRunningFlag, 1'b0);
    check(remoteBits.revRunningFlag, 1'b1);
    setDs(17'h02001);
    check(remoteBits.atSpeedFlag, 1'b1);
    setDs(17'h01001);
    check(remoteBits.overloadFlag, 1'b1);
    setDs(17'h00005);
    check(remoteBits.errorFlag, 1'b1);
    check(remoteBits.stationReady, 1'b0);
    setDs(17'h1FFFF);
    check(remoteBits, 16'h0000);
  endtask : dirTest
  task hsTest;
    setDs(17'h00001);
    check(remoteBits.stationReady, 1'b1);
    @(posedge clk) instrFail <= 1'b1;
    mstU.handshake(CH_INSTR, ok);
    check(ok, 1'b1);
    check(replyCode, REPLY_FAIL);
    @(posedge clk) instrFail <= 1'b0;
    for (int ch = 0; ch < NUM_CMD; ch++) begin
      mstU.handshake(ch, ok);
      check(ok, 1'b1);
    end
    check(replyCode, REPLY_OK);
  endtask : hsTest
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    regsTest;
    codeTest;
    dirTest;
    hsTest;
    endSim;
  end
  initial begin
    #100000;
    failCount++;
    endSim;
  end
endmodule : test_remote_status_bit_mapper
bind remote_status_bit_mapper remote_map_asserts chkU (.clk(clk),
  .rst_b(rst_b), .driveState(driveState),
  .instructionRequest(instructionRequest), .cmdDone(cmdDone),
  .remoteBits(remoteBits));
